// >>> core/ivm_pkg.sv
// Purpose: Constants for the interrupt vector map block
// Assumes: Vector offsets are byte offsets from a 256-byte aligned pointer
// Notes:   Priority position equals the interrupt number

package ivm_pkg;

  // Number of interrupt slots and flag word width
  localparam int unsigned NUM_INT   = 32;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned PTR_W     = 16;
  localparam int unsigned ADDR_W    = 24;

  // Interrupt numbers of the mapped sources
  localparam int unsigned N_NMI     = 1;
  localparam int unsigned N_EXT3    = 11;
  localparam int unsigned N_EXT4    = 16;
  localparam int unsigned N_RX2     = 17;
  localparam int unsigned N_TX2     = 18;
  localparam int unsigned N_DMA2    = 19;
  localparam int unsigned N_DMA3    = 20;
  localparam int unsigned N_DMA4    = 21;
  localparam int unsigned N_DMA5    = 22;
  localparam int unsigned N_TMR1    = 23;
  localparam int unsigned N_TWS     = 24;
  localparam int unsigned N_LOG     = 25;
  localparam int unsigned N_OS      = 26;
  localparam int unsigned N_SW_LO   = 27;

  // Host-page pointer range
  localparam int unsigned HOST_LO   = 16;
  localparam int unsigned HOST_HI   = 23;

  // Vector offsets indexed by interrupt number
  localparam logic [7:0] VEC_OFS [NUM_INT] = '{
    8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38,
    8'h40, 8'h48, 8'h50, 8'h58, 8'h80, 8'h88, 8'h90, 8'hC0,
    8'h98, 8'h60, 8'h68, 8'hA0, 8'hA8, 8'h70, 8'h78, 8'hB0,
    8'hB8, 8'hC8, 8'hD0, 8'hD8, 8'hE0, 8'hE8, 8'hF0, 8'hF8};

  // Pin filter pattern: oldest sample first, 1-1-0-0-0
  localparam int unsigned FILT_LEN  = 5;
  localparam logic [4:0]  FILT_PAT  = 5'b1_1000;

  // Reset values
  localparam logic [PTR_W-1:0]  PTR_RST  = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

endpackage

// >>> core/ivm_top.sv
// Purpose: Maps interrupt events to flags, enables, priority and vectors
// Assumes: Single CPU clock; pins are asynchronous and active low
// Notes:   Software clears flags and writes enables through plain ports, no bus
//          Pins 0..2 land in slots 2, 3 and 10; pins 3 and 4 share
//          their slots with the watchdog and the clock event
//          Pins are sampled on falling edges, everything else on rising
//
// Function
// - Pointer select: 16-23 host page, rest data
// - Nonmaskable input tied inactive; slot reused
// - Pin four and clock share 98h, 16
// - Serial port two: 60h/17, 68h/18
// - Transfer channels 2-5 at A0,A8,70,78
// - Timer one B0h/23, two-wire B8h/24
// - Data log C8h/25, os event D0h/26
// - Software 27-31 at D8h..F8h step eight
// - Held-low pin four blocks clock event
// - Pin three and watchdog share flag
// - Pin four and clock share flag
// - Two-stage sync, falling edge, 11000 pattern

`timescale 1ns/1ps

module ivm_top #(
  parameter int unsigned EXT_N = 5
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              ARST_N_IN,
  input  wire logic [EXT_N-1:0]  EXT_REQ_N_IN,
  input  wire logic [31:0]       PERIPH_EVT_IN,
  input  wire logic              WDOG_EVT_IN,
  input  wire logic              RTC_EVT_IN,
  input  wire logic              SW_REQ_ONE_IN,
  input  wire logic [15:0]       PTR_DATA_IN,
  input  wire logic [15:0]       PTR_HOST_IN,
  input  wire logic              PTR_WR_IN,
  input  wire logic [31:0]       FLAG_CLR_IN,
  input  wire logic              ENABLE_WR_IN,
  input  wire logic [31:0]       ENABLE_IN,
  input  wire logic              ACK_IN,
  output logic      [31:0]       FLAG_OUT,
  output logic      [31:0]       ENABLE_OUT,
  output logic                   IRQ_OUT,
  output logic      [4:0]        IRQ_NUM_OUT,
  output logic      [23:0]       VECTOR_OUT
);

  localparam int unsigned N = ivm_pkg::NUM_INT;
  localparam int unsigned W = ivm_pkg::WORD_W;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and pattern filters
  ////////////////////////////////////////////////////////////////////////

  logic [EXT_N-1:0] sync1_q;
  logic [EXT_N-1:0] sync2_q;
  logic [EXT_N-1:0] pin_det;
  logic [EXT_N-1:0] pin_low;

  // Falling-edge sampling halves the settling window, which the
  // 1-1-0-0-0 filter tolerates since a low must last three cycles
  always_ff @(negedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= EXT_REQ_N_IN;
      sync2_q <= sync1_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < EXT_N; gi++) begin : g_pin
      logic [ivm_pkg::FILT_LEN-1:0] sh_q;
      // Shift history of synchronised samples, newest in bit 0
      always_ff @(negedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
          sh_q <= '1;
        end else begin
          sh_q <= {sh_q[ivm_pkg::FILT_LEN-2:0], sync2_q[gi]};
        end
      end
      assign pin_det[gi] = (sh_q == ivm_pkg::FILT_PAT);
      // Newest filtered sample; low means the pin is still asserted
      assign pin_low[gi] = ~sh_q[0];
    end
  endgenerate

  // Detection pulses move to the rising-edge domain of the core
  logic [EXT_N-1:0] det_q;
  logic             pin4_low_q;

  // Half a cycle of margin: the filter settles at the falling edge
  // and is taken at the next rising edge
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      det_q <= '0;
    end else begin
      det_q <= pin_det;
    end
  end

  // Level of pin four, masks the clock event while the pin is held low
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pin4_low_q <= 1'b0;
    end else begin
      pin4_low_q <= pin_low[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event mapping into interrupt slots
  ////////////////////////////////////////////////////////////////////////

  logic [N-1:0] evt;
  logic         rtc_seen;

  // Clock event is only seen while pin four sits high; a held-low
  // pin hides it, so users should pick one of the two sources
  assign rtc_seen = RTC_EVT_IN & ~pin4_low_q;

  // Slot map at a glance:
  //   1      software one or watchdog; the nonmaskable pin never fires
  //   11     pin three or watchdog, one shared flag
  //   16     pin four or clock event, one shared flag
  //   27-31  no source at all, events tied to zero
  always_comb begin
    evt = PERIPH_EVT_IN;
    // Pins occupy slots 2,3,10,11 and 16; nonmaskable never fires
    evt[ivm_pkg::N_NMI]  = SW_REQ_ONE_IN | WDOG_EVT_IN;
    evt[2]               = PERIPH_EVT_IN[2] | det_q[0];
    evt[3]               = PERIPH_EVT_IN[3] | det_q[1];
    evt[10]              = PERIPH_EVT_IN[10] | det_q[2];
    evt[ivm_pkg::N_EXT3] = det_q[3] | WDOG_EVT_IN;
    evt[ivm_pkg::N_EXT4] = det_q[4] | rtc_seen;
    evt[ivm_pkg::N_RX2]  = PERIPH_EVT_IN[ivm_pkg::N_RX2];
    evt[ivm_pkg::N_TX2]  = PERIPH_EVT_IN[ivm_pkg::N_TX2];
    for (int i = ivm_pkg::N_SW_LO; i < N; i++) begin
      evt[i] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag words and enable words
  ////////////////////////////////////////////////////////////////////////

  logic [N-1:0] flag_q;
  logic [N-1:0] enable_q;
  logic [N-1:0] take;
  logic [N-1:0] flag_keep;
  logic [W-1:0] flag_word_zero_q;
  logic [W-1:0] flag_word_one_q;
  logic [W-1:0] enable_word_zero_q;
  logic [W-1:0] enable_word_one_q;

  // Bits survive unless software clears them or the core accepts them
  assign flag_keep = flag_q & ~FLAG_CLR_IN & ~take;

  // Slots 0-15; an event in the same cycle as a clear keeps the flag
  // set, so a clear racing a fresh event never loses the event
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      flag_word_zero_q <= ivm_pkg::WORD_RST;
    end else begin
      flag_word_zero_q <= flag_keep[W-1:0] | evt[W-1:0];
    end
  end

  // Slots 16-31, same set-wins rule as the lower word
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      flag_word_one_q <= ivm_pkg::WORD_RST;
    end else begin
      flag_word_one_q <= flag_keep[N-1:W] | evt[N-1:W];
    end
  end

  // Enable words change only on an explicit write; both load in one
  // cycle so a half-written mask is never forwarded
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      enable_word_zero_q <= ivm_pkg::WORD_RST;
    end else if (ENABLE_WR_IN) begin
      enable_word_zero_q <= ENABLE_IN[W-1:0];
    end
  end

  // Upper enable word, slots 16-31
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      enable_word_one_q <= ivm_pkg::WORD_RST;
    end else if (ENABLE_WR_IN) begin
      enable_word_one_q <= ENABLE_IN[N-1:W];
    end
  end

  assign flag_q     = {flag_word_one_q, flag_word_zero_q};
  assign enable_q   = {enable_word_one_q, enable_word_zero_q};
  assign FLAG_OUT   = flag_q;
  assign ENABLE_OUT = enable_q;

  ////////////////////////////////////////////////////////////////////////
  // Vector pointers
  ////////////////////////////////////////////////////////////////////////

  logic [15:0] ptr_data_q;
  logic [15:0] ptr_host_q;

  // Data-page pointer: base for slots 0-15 and 24-31
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ptr_data_q <= ivm_pkg::PTR_RST;
    end else if (PTR_WR_IN) begin
      ptr_data_q <= PTR_DATA_IN;
    end
  end

  // Host-page pointer: base for slots 16-23 only
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ptr_host_q <= ivm_pkg::PTR_RST;
    end else if (PTR_WR_IN) begin
      ptr_host_q <= PTR_HOST_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Priority selection and vector formation
  ////////////////////////////////////////////////////////////////////////

  logic [N-1:0] pend;
  logic         any_pend;
  logic [4:0]   win;
  logic [15:0]  base;

  assign pend = flag_q & enable_q;

  // Lowest number wins, since priority equals interrupt number
  always_comb begin
    win      = '0;
    any_pend = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win      = i[4:0];
        any_pend = 1'b1;
      end
    end
  end

  // Host page only for slots 16 through 23
  always_comb begin
    if (win >= 5'(ivm_pkg::HOST_LO) && win <= 5'(ivm_pkg::HOST_HI)) begin
      base = ptr_host_q;
    end else begin
      base = ptr_data_q;
    end
  end

  // Offsets come from one table: ..live in its entries
  logic [23:0] vec_d;
  assign vec_d = {base, ivm_pkg::VEC_OFS[win]};

  // Request is held until the core acknowledges; ack clears the flag
  logic        irq_q;
  logic [4:0]  num_q;
  logic [23:0] vec_q;

  // Request level: low for one cycle after every accept, so the core
  // never takes the same presentation twice
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= any_pend & ~(ACK_IN & irq_q);
    end
  end

  // Number of the winning slot, refreshed every cycle
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      num_q <= '0;
    end else begin
      num_q <= win;
    end
  end

  // Vector of the winning slot; loads with the number so both pair
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      vec_q <= '0;
    end else begin
      vec_q <= vec_d;
    end
  end

  // Acknowledge retires only the slot being presented
  always_comb begin
    take = '0;
    if (ACK_IN && irq_q) begin
      take[num_q] = 1'b1;
    end
  end

  assign IRQ_OUT     = irq_q;
  assign IRQ_NUM_OUT = num_q;
  assign VECTOR_OUT  = vec_q;

endmodule

// >>> testbench/ivm_checker_assertions.sv
// Purpose: Port checks for the interrupt vector map
// Assumes: Events arrive only while no request is pending
// Notes:   Bound to ivm_top below the module
`timescale 1ns/1ps
module ivm_checker #(parameter int unsigned EXT_N = 5) (
  input wire logic             SYS_CLK_IN,
  input wire logic             ARST_N_IN,
  input wire logic [EXT_N-1:0] EXT_REQ_N_IN,
  input wire logic [31:0]      PERIPH_EVT_IN,
  input wire logic             WDOG_EVT_IN,
  input wire logic             RTC_EVT_IN,
  input wire logic             ACK_IN,
  input wire logic [31:0]      FLAG_OUT,
  input wire logic [31:0]      ENABLE_OUT,
  input wire logic             IRQ_OUT,
  input wire logic [4:0]       IRQ_NUM_OUT,
  input wire logic [23:0]      VECTOR_OUT
);
  // One domain, so clock and reset are named once
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  chk_vec_offset: assert property (
    IRQ_OUT |-> VECTOR_OUT[7:0] == ivm_pkg::VEC_OFS[IRQ_NUM_OUT])
    else $error("bad vector offset");
  chk_event_flag: assert property (
    (PERIPH_EVT_IN & 32'h07FE_F7FD) != 32'h0000_0000 |=>
    ($past(PERIPH_EVT_IN) & 32'h07FE_F7FD & ~FLAG_OUT) == 32'h0000_0000)
    else $error("event flag not set");
  chk_wdog_shared: assert property (
    WDOG_EVT_IN |=> FLAG_OUT[1] && FLAG_OUT[11])
    else $error("watchdog flags not set");
  chk_rtc_flag: assert property (
    (EXT_REQ_N_IN[4])[*8] ##0 RTC_EVT_IN |=> FLAG_OUT[16])
    else $error("clock event flag not set");
  chk_rtc_held: assert property (
    (!EXT_REQ_N_IN[4])[*8] ##0 (RTC_EVT_IN && !FLAG_OUT[16]) |=> !FLAG_OUT[16])
    else $error("clock event seen while pin low");
  chk_pin_detect: assert property (
    (EXT_REQ_N_IN[4])[*3] ##1 (!EXT_REQ_N_IN[4])[*4] |-> ##[1:8] FLAG_OUT[16])
    else $error("pin four not detected");
  chk_ack_drop: assert property (
    IRQ_OUT && ACK_IN |=> !IRQ_OUT)
    else $error("request held after accept");
  chk_irq_raise: assert property (
    !IRQ_OUT && (FLAG_OUT & ENABLE_OUT) != 32'h0000_0000 |-> ##[1:2] IRQ_OUT)
    else $error("enabled flag not forwarded");
  cov_ack: cover property (IRQ_OUT && ACK_IN);
  cov_held: cover property ((!EXT_REQ_N_IN[4])[*8] ##0 RTC_EVT_IN);
  cov_wdog: cover property (WDOG_EVT_IN);
endmodule
bind ivm_top ivm_checker #(.EXT_N(EXT_N)) u_chk (.*);

// >>> testbench/ivm_core_model.sv
// Purpose: Core side that accepts requests and fetches vectors
// Assumes: Accept is a one-cycle pulse while the request stands
// Notes:   Slow mode waits a few cycles so the request must hold
`timescale 1ns/1ps
module ivm_core_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        irq_in,
  input  wire logic [4:0]  num_in,
  input  wire logic [23:0] vec_in,
  input  wire logic        slow_in,
  output logic             ack_out,
  output logic [4:0]       num_out,
  output logic [23:0]      vec_out,
  output int               cnt_out
);
  int wait_q;
  // Accept after a delay; take number and vector at the accepting edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'h0;
      wait_q  <= 0;
      cnt_out <= 0;
      num_out <= 5'h00;
      vec_out <= 24'h00_0000;
    end else if (ack_out) begin
      ack_out <= 1'h0;
      wait_q  <= 0;
      num_out <= num_in;
      vec_out <= vec_in;
      cnt_out <= cnt_out + 1;
    end else if (irq_in) begin
      wait_q  <= wait_q + 1;
      ack_out <= (wait_q >= (slow_in ? 4 : 0));
    end
  end
endmodule

// >>> testbench/interrupt_vector_map_bench.sv
// Purpose: Self-checking bench for the interrupt vector map
// Assumes: One event in flight at a time once enables are on
// Notes:   Seeded random slots, pointers and core delays
`timescale 1ns/1ps
module interrupt_vector_map_bench;
  localparam logic [31:0] SLOTS = 32'h07FF_F7FF;
  logic clk = 1'h0, rst_n = 1'h0, wd = 1'h0, rtc = 1'h0, sw = 1'h0;
  logic pw = 1'h0, ew = 1'h0, slow = 1'h0, ack, irq;
  logic [4:0] xn = 5'h1F, num, a_num;
  logic [15:0] pd = 16'h0000, ph = 16'h0000;
  logic [31:0] evt = 32'h0000_0000, clr = 32'h0000_0000, flag, enq;
  logic [23:0] vec, a_vec;
  int err_total = 0, samples_checked = 0, seed = 89, a_cnt, c, n;
  always #5 clk = ~clk;
  ivm_top DUT (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .EXT_REQ_N_IN(xn),
    .PERIPH_EVT_IN(evt), .WDOG_EVT_IN(wd), .RTC_EVT_IN(rtc),
    .SW_REQ_ONE_IN(sw), .PTR_DATA_IN(pd), .PTR_HOST_IN(ph), .PTR_WR_IN(pw),
    .FLAG_CLR_IN(clr), .ENABLE_WR_IN(ew), .ENABLE_IN(32'hFFFF_FFFF),
    .ACK_IN(ack), .FLAG_OUT(flag), .ENABLE_OUT(enq), .IRQ_OUT(irq),
    .IRQ_NUM_OUT(num), .VECTOR_OUT(vec));
  ivm_core_model u_core (.clk_in(clk), .rst_n_in(rst_n), .irq_in(irq),
    .num_in(num), .vec_in(vec), .slow_in(slow), .ack_out(ack),
    .num_out(a_num), .vec_out(a_vec), .cnt_out(a_cnt));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_vec(int s);
    exp_vec = {8'h00, (s > 15 && s < 24) ? ph : pd, ivm_pkg::VEC_OFS[s]};
  endfunction
  // Drive just after the edge so sampling never races
  task automatic tick(int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic cmp(string s, logic [31:0] e, logic [31:0] v);
    samples_checked++;
    if (e !== v) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic summarize;
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One-cycle pulse on {watchdog, software one, clock event, peripherals}
  task automatic hit(logic [34:0] v);
    {wd, sw, rtc, evt} = v;
    tick();
    {wd, sw, rtc, evt} = 35'h0_0000_0000;
  endtask
  task automatic wipe;
    clr = 32'hFFFF_FFFF;
    tick();
    clr = 32'h0000_0000;
  endtask
  // Raise one slot, wait for the core to take it, check the fetch
  task automatic fire(int s);
    c = a_cnt;
    hit(s == 16 ? 35'h1_0000_0000 : s == 1 ? 35'h2_0000_0000 :
        35'h0_0000_0001 << s);
    for (int i = 0; i < 20 && a_cnt == c; i++) tick();
    cmp("accepts", 32'(c + 1), 32'(a_cnt));
    cmp("slot", 32'(s), {27'h000_0000, a_num});
    cmp("vector", exp_vec(s), {8'h00, a_vec});
    cmp("flags", 32'h0000_0000, flag);
  endtask
  initial begin
    #500000;
    err_total++;
    summarize();
  end
  initial begin
    tick(10);
    rst_n = 1'h1;
    pd = 16'($random(seed));
    ph = 16'($random(seed));
    pw = 1'h1;
    tick();
    pw = 1'h0;
    // Enables still clear: flags collect, nothing reaches the core
    hit(35'h4_0000_0000);
    cmp("flags", 32'h0000_0802, flag);
    wipe();
    hit(35'h3_0000_0000);
    cmp("flags", 32'h0001_0002, flag);
    xn = 5'h1E;
    tick(2);
    xn = 5'h1F;
    tick(12);
    cmp("flags", 32'h0001_0002, flag);
    xn = 5'h12;
    tick(3);
    xn = 5'h1F;
    tick(12);
    cmp("flags", 32'h0001_0C06, flag);
    cmp("irq", 32'h0000_0000, {31'h0000_0000, irq});
    wipe();
    // Pin four held low hides the clock event until it rises
    xn = 5'h0F;
    tick(12);
    cmp("flags", 32'h0001_0000, flag);
    wipe();
    hit(35'h1_0000_0000);
    cmp("flags", 32'h0000_0000, flag);
    xn = 5'h1F;
    tick(12);
    hit(35'h1_0000_0000);
    cmp("flags", 32'h0001_0000, flag);
    wipe();
    ew = 1'h1;
    tick();
    ew = 1'h0;
    cmp("enables", 32'hFFFF_FFFF, enq);
    for (int s = 0; s < 27; s++) if (SLOTS[s]) fire(s);
    // Random slots with a randomly slow core
    repeat (30) begin
      do n = int'($unsigned($random(seed)) % 27); while (!SLOTS[n]);
      slow = 1'($random(seed));
      fire(n);
    end
    // Reset in mid-run with a flag pending: all clears, pointers too
    hit(35'h0_0000_0004);
    rst_n = 1'h0;
    tick();
    cmp("flags", 32'h0000_0000, flag);
    cmp("enables", 32'h0000_0000, enq);
    cmp("irq", 32'h0000_0000, {31'h0000_0000, irq});
    rst_n = 1'h1;
    pd = 16'h0000;
    ph = 16'h0000;
    tick(2);
    ew = 1'h1;
    tick();
    ew = 1'h0;
    fire(5);
    fire(17);
    summarize();
  end
endmodule
